// file: core/vpiu_regs.vh
// Register offsets, field positions, vectors and reset values of the vectored interrupt unit
`ifndef VPIU_REGS_VH
`define VPIU_REGS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define VPIU_OFF_MASK    12'h000
`define VPIU_OFF_PRIO_LO 12'h004
`define VPIU_OFF_PRIO_HI 12'h008
`define VPIU_OFF_CTRL    12'h00C
`define VPIU_OFF_SPLIM   12'h010
`define VPIU_OFF_STATUS  12'h014
`define VPIU_OFF_WAKE_EN 12'h018

// ****************************************
// Control and status fields
// ****************************************
`define VPIU_CTRL_STK_EN 0
`define VPIU_CTRL_SWRST  1
`define VPIU_CTRL_DONE   2
`define VPIU_ST_ACTV_VLD 8

// ****************************************
// Vector addresses
// ****************************************
`define VPIU_VEC_BUS_ERR 32'h00000008
`define VPIU_VEC_TICK    32'h0000000E
`define VPIU_VEC_ALIGN   32'h00000014
`define VPIU_VEC_ILLEGAL 32'h0000001A
`define VPIU_VEC_HW_IRQ  32'h00000020
`define VPIU_VEC_SYSCALL 32'h00000026
`define VPIU_VEC_TRAP    32'h0000002C
`define VPIU_VEC_RESET   32'h00000038
`define VPIU_VEC_STK_OVF 32'h0000003E

// ****************************************
// Sources, sizes and reset values
// ****************************************
`define VPIU_NSRC        16
`define VPIU_LVL_W       4
`define VPIU_DIO_SRC     16'h00FF
`define VPIU_SIZE_HALF   2'h1
`define VPIU_SIZE_WORD   2'h2
`define VPIU_RST_MASK    16'h0000
`define VPIU_RST_PRIO    32'h00000000
`define VPIU_RST_SPLIM   32'h00000000
`define VPIU_RST_WAKE_EN 16'h0000

`endif

// file: core/vpiu_prio_sel.v
// Highest-level pending source selector for the priority interrupt controller
`timescale 1ns/1ps
module vpiu_prio_sel (
  input  wire [15:0] pend,
  input  wire [63:0] prio,
  output reg  [3:0]  best_lvl,
  output reg  [3:0]  best_idx
);

  wire [3:0] eff_lvl [0:15];
  integer    i;

  // Level 0 or no request gives an effective level of zero
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_src
      assign eff_lvl[g] = pend[g] ? prio[g*4 +: 4] : 4'h0;
    end
  endgenerate

  // Strict compare in ascending order: lowest index wins a tie
  always @* begin
    best_lvl = 4'h0;
    best_idx = 4'h0;
    for (i = 0; i < 16; i = i + 1) begin
      if (eff_lvl[i] > best_lvl) begin
        best_lvl = eff_lvl[i];
        best_idx = i[3:0];
      end
    end
  end

endmodule

// file: core/vpiu_top.v
// Vectored exception and priority interrupt unit with APB register access
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "vpiu_regs.vh"
module vpiu_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  input  wire        bus_valid,
  input  wire        bus_write,
  input  wire [1:0]  bus_size,
  input  wire [31:0] bus_addr,
  input  wire        addr_exists,
  input  wire        addr_populated,
  input  wire        addr_is_rom,
  input  wire        fetch_valid,
  input  wire        fetch_unknown,
  input  wire        syscall_exec,
  input  wire        trap_exec,
  input  wire        debug_trap,
  input  wire        tick_irq,
  input  wire        sp_write,
  input  wire [31:0] sp_value,
  input  wire [15:0] irq_src,
  input  wire        sleep_mode,
  input  wire        supervisor_exit,
  output reg         redirect,
  output reg  [31:0] redirect_pc,
  output reg         supervisor,
  output wire        ext_irq,
  output reg         wake_req
);

  // ****************************************
  // Registers and state
  // ****************************************
  reg  [15:0] irq_mask;
  reg  [31:0] prio_lo;
  reg  [31:0] prio_hi;
  reg         stk_en;
  reg  [31:0] sp_limit;
  reg  [15:0] wake_en;
  reg  [15:0] active_lvls;
  reg  [3:0]  last_src;
  reg         rst_pend;
  reg         acc_q;
  reg  [3:0]  cur_lvl;
  reg  [31:0] next_pc;
  reg         next_take;
  reg         take_irq;
  reg         sel_hit;
  reg  [31:0] sel_data;
  wire [3:0]  best_lvl;
  wire [3:0]  best_idx;
  wire [15:0] pend;
  wire        wr_en;
  wire        rd_en;
  wire        bus_err;
  wire        misalign;
  wire        illegal;
  wire        stk_ovf;
  wire        trap_ev;
  wire        done_wr;
  wire        swrst_wr;
  integer     k;
  integer     j;

  // ****************************************
  // APB slave
  // ****************************************
  // One wait state so read data leaves a flip-flop
  assign pready   = psel & penable & acc_q;
  assign wr_en    = pready & pwrite;
  assign rd_en    = psel & penable & ~acc_q & ~pwrite;
  assign done_wr  = wr_en & (paddr == `VPIU_OFF_CTRL) & pwdata[`VPIU_CTRL_DONE];
  assign swrst_wr = wr_en & (paddr == `VPIU_OFF_CTRL) & pwdata[`VPIU_CTRL_SWRST];

  always @* begin
    sel_hit  = 1'b1;
    sel_data = 32'h00000000;
    case (paddr)
      `VPIU_OFF_MASK:    sel_data = {16'h0000, irq_mask};
      `VPIU_OFF_PRIO_LO: sel_data = prio_lo;
      `VPIU_OFF_PRIO_HI: sel_data = prio_hi;
      `VPIU_OFF_CTRL:    sel_data = {31'h00000000, stk_en};
      `VPIU_OFF_SPLIM:   sel_data = sp_limit;
      `VPIU_OFF_STATUS:  sel_data = {16'h0000, 7'h00, |active_lvls, best_idx, cur_lvl};
      `VPIU_OFF_WAKE_EN: sel_data = {16'h0000, wake_en};
      default:           sel_hit  = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q   <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      acc_q <= psel & penable & ~acc_q;
      if (psel & penable & ~acc_q) begin
        pslverr <= ~sel_hit;
        prdata  <= rd_en ? sel_data : 32'h00000000;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= `VPIU_RST_MASK;
      prio_lo  <= `VPIU_RST_PRIO;
      prio_hi  <= `VPIU_RST_PRIO;
      stk_en   <= 1'b0;
      sp_limit <= `VPIU_RST_SPLIM;
      wake_en  <= `VPIU_RST_WAKE_EN;
    end else if (wr_en) begin
      case (paddr)
        `VPIU_OFF_MASK:    irq_mask <= pwdata[15:0];
        `VPIU_OFF_PRIO_LO: prio_lo  <= pwdata;
        `VPIU_OFF_PRIO_HI: prio_hi  <= pwdata;
        `VPIU_OFF_CTRL:    stk_en   <= pwdata[`VPIU_CTRL_STK_EN];
        `VPIU_OFF_SPLIM:   sp_limit <= pwdata;
        `VPIU_OFF_WAKE_EN: wake_en  <= pwdata[15:0];
        default:           stk_en   <= stk_en;
      endcase
    end
  end

  // ****************************************
  // Priority interrupt controller
  // ****************************************
  assign pend = irq_src & irq_mask;

  vpiu_prio_sel u_sel (
    .pend     (pend),
    .prio     ({prio_hi, prio_lo}),
    .best_lvl (best_lvl),
    .best_idx (best_idx)
  );

  // Nested levels rise strictly, so a bitmap of active levels is a full stack
  always @* begin
    cur_lvl = 4'h0;
    for (k = 1; k < 16; k = k + 1) begin
      if (active_lvls[k]) begin
        cur_lvl = k[3:0];
      end
    end
  end

  // Controller is powered down in sleep and raises nothing then
  assign ext_irq = ~sleep_mode & (best_lvl > cur_lvl);

  // ****************************************
  // Exception detection
  // ****************************************
  assign bus_err  = bus_valid & (~addr_exists | ~addr_populated | (bus_write & addr_is_rom));
  assign misalign = bus_valid & (((bus_size == `VPIU_SIZE_HALF) & bus_addr[0]) |
                                 ((bus_size == `VPIU_SIZE_WORD) & (bus_addr[1:0] != 2'h0)));
  assign illegal  = fetch_valid & fetch_unknown;
  assign stk_ovf  = stk_en & sp_write & (sp_value <= sp_limit);
  assign trap_ev  = trap_exec | debug_trap;

  // Fixed arbitration: reset first, hardware interrupt last
  always @* begin
    next_take = 1'b1;
    take_irq  = 1'b0;
    next_pc   = `VPIU_VEC_RESET;
    if (rst_pend) begin
      next_pc = `VPIU_VEC_RESET;
    end else if (bus_err) begin
      next_pc = `VPIU_VEC_BUS_ERR;
    end else if (misalign) begin
      next_pc = `VPIU_VEC_ALIGN;
    end else if (illegal) begin
      next_pc = `VPIU_VEC_ILLEGAL;
    end else if (stk_ovf) begin
      next_pc = `VPIU_VEC_STK_OVF;
    end else if (trap_ev) begin
      next_pc = `VPIU_VEC_TRAP;
    end else if (syscall_exec) begin
      next_pc = `VPIU_VEC_SYSCALL;
    end else if (tick_irq) begin
      next_pc = `VPIU_VEC_TICK;
    end else if (ext_irq) begin
      next_pc  = `VPIU_VEC_HW_IRQ;
      take_irq = 1'b1;
    end else begin
      next_take = 1'b0;
    end
  end

  // ****************************************
  // Redirect, mode and nesting state
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_pend    <= 1'b1;
      redirect    <= 1'b0;
      redirect_pc <= 32'h00000000;
      supervisor  <= 1'b1;
      active_lvls <= 16'h0000;
      last_src    <= 4'h0;
    end else begin
      redirect <= next_take;
      if (next_take) begin
        redirect_pc <= next_pc;
      end
      // Entry wins over a simultaneous exit request
      if (next_take) begin
        supervisor <= 1'b1;
      end else if (supervisor_exit) begin
        supervisor <= 1'b0;
      end
      if (swrst_wr) begin
        rst_pend <= 1'b1;
      end else if (rst_pend) begin
        rst_pend <= 1'b0;
      end
      if (rst_pend) begin
        active_lvls <= 16'h0000;
      end else begin
        // A new higher level wins: a done write in the same cycle leaves the current level active
        // Separate loop index keeps this process from sharing a variable with the level decoder
        for (j = 1; j < 16; j = j + 1) begin
          if (take_irq && best_lvl == j[3:0]) begin
            active_lvls[j] <= 1'b1;
          end else if (done_wr && !take_irq && cur_lvl == j[3:0]) begin
            active_lvls[j] <= 1'b0;
          end
        end
      end
      if (take_irq) begin
        last_src <= best_idx;
      end
    end
  end

  // ****************************************
  // Sleep wake-up
  // ****************************************
  // Pin sources always wake; others only when their wake enable is set
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_req <= 1'b0;
    end else begin
      wake_req <= sleep_mode & |(irq_src & (`VPIU_DIO_SRC | wake_en));
    end
  end

endmodule

// file: verif/vpiu_checker.sv
// Port-level assertions for the vectored interrupt unit
`timescale 1ns/1ps
module vpiu_checker (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pready,
  input wire        bus_valid,
  input wire        bus_write,
  input wire [1:0]  bus_size,
  input wire [31:0] bus_addr,
  input wire        addr_exists,
  input wire        addr_populated,
  input wire        fetch_valid,
  input wire        syscall_exec,
  input wire        trap_exec,
  input wire        debug_trap,
  input wire        tick_irq,
  input wire        sp_write,
  input wire        sleep_mode,
  input wire        redirect,
  input wire [31:0] redirect_pc,
  input wire        supervisor,
  input wire        ext_irq
);
  // No other event this cycle, so a lower-ranked event is the one taken
  wire quiet = !(bus_valid | fetch_valid | syscall_exec | trap_exec | debug_trap | tick_irq | sp_write);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready not after one wait");
  a_syscall_vec:
    assert property (syscall_exec && !bus_valid && !fetch_valid && !trap_exec && !debug_trap && !sp_write
      |=> redirect && redirect_pc == 32'h00000026) else $error("system call vector");
  a_trap_vec:
    assert property ((trap_exec || debug_trap) && !bus_valid && !fetch_valid && !sp_write
      |=> redirect && redirect_pc == 32'h0000002C) else $error("trap vector");
  a_bus_err:
    assert property (bus_valid && !addr_exists |=> redirect && redirect_pc == 32'h00000008)
      else $error("bus error vector");
  a_align_word:
    assert property (bus_valid && addr_exists && addr_populated && !bus_write && bus_size == 2'h2
      && bus_addr[1:0] != 2'h0 |=> redirect_pc == 32'h00000014) else $error("misaligned word");
  a_irq_take:
    assert property (ext_irq && quiet |=> redirect && redirect_pc == 32'h00000020)
      else $error("hardware interrupt not taken");
  a_entry_super:
    assert property (redirect |-> supervisor)
      else $error("handler entered outside supervisor mode");
  a_sleep_quiet:
    assert property (sleep_mode |-> !ext_irq)
      else $error("interrupt raised during sleep");
endmodule
bind vpiu_top vpiu_checker vpiu_checker_i (.*);

// file: verif/vpiu_core_model.sv
// Processor core stand-in: leaves handlers on request, counts taken hardware interrupts
`timescale 1ns/1ps
module vpiu_core_model (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        redirect,
  input  wire [31:0] redirect_pc,
  input  wire        leave,
  output reg         supervisor_exit,
  output reg  [7:0]  n_irq
);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supervisor_exit <= 1'b0;
      n_irq           <= 8'h00;
    end else begin
      supervisor_exit <= leave;
      if (redirect && redirect_pc == 32'h00000020)
        n_irq <= n_irq + 8'h01;
    end
  end
endmodule

// file: verif/vectored_priority_interrupt_unit_tb.sv
// Self-checking bench for the vectored interrupt unit
`timescale 1ns/1ps
module vectored_priority_interrupt_unit_tb;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h00000000;
  reg  [6:0]  ev = 7'h00;
  reg  [7:0]  bcfg = 8'h58;
  reg  [15:0] irq = 16'h0000;
  reg         sleep = 1'b0;
  reg         leave = 1'b0;
  reg  [31:0] q;
  reg         err;
  integer     bad_count = 0;
  integer     n_checks = 0;
  wire        pready, pslverr, redirect, supervisor, ext_irq, wake_req, sx;
  wire [31:0] prdata, redirect_pc;
  wire [7:0]  n_irq;
  always #12.5 pclk = ~pclk;
  // ****
  // bcfg: write, size, exists, populated, rom, address low bits
  // ****
  vpiu_top vpiu_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .bus_valid(ev[5]),
    .bus_write(bcfg[7]), .bus_size(bcfg[6:5]), .bus_addr({30'h00000400, bcfg[1:0]}), .addr_exists(bcfg[4]),
    .addr_populated(bcfg[3]), .addr_is_rom(bcfg[2]), .fetch_valid(ev[3]), .fetch_unknown(1'b1),
    .syscall_exec(ev[0]), .trap_exec(ev[1]), .debug_trap(ev[2]), .tick_irq(ev[4]), .sp_write(ev[6]),
    .sp_value(32'h00000100), .irq_src(irq), .sleep_mode(sleep), .supervisor_exit(sx), .redirect(redirect),
    .redirect_pc(redirect_pc), .supervisor(supervisor), .ext_irq(ext_irq), .wake_req(wake_req));
  vpiu_core_model vpiu_core_model_i (.pclk(pclk), .presetn(presetn), .redirect(redirect),
    .redirect_pc(redirect_pc), .leave(leave), .supervisor_exit(sx), .n_irq(n_irq));
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("wrong value %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task chkb(input string nm, input e, input g);
    chk(nm, {31'h00000000, e}, {31'h00000000, g});
  endtask
  task step(input integer n);
    begin
      repeat (n) @(posedge pclk);
      #1;
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task cpu(input [6:0] e, input [7:0] b, input [31:0] vec, input r);
    begin
      @(posedge pclk);
      ev <= e;
      bcfg <= b;
      @(posedge pclk);
      ev <= 7'h00;
      #1;
      chkb("redirect", r, redirect);
      if (r) begin
        chk("vector", vec, redirect_pc);
        chkb("supervisor", 1'b1, supervisor);
      end
    end
  endtask
  task irq_set(input [15:0] v);
    begin
      @(posedge pclk);
      irq <= v;
      #1;
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    repeat (4000) @(posedge pclk);
    bad_count = bad_count + 1;
    final_report;
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    step(2);
    chk("reset vector", 32'h00000038, redirect_pc);
    apb(1'b0, 12'h000, 32'h00000000);
    chk("mask", 32'h00000000, q);
    @(posedge pclk);
    leave <= 1'b1;
    @(posedge pclk);
    leave <= 1'b0;
    step(2);
    chkb("handler left", 1'b0, supervisor);
    cpu(7'h01, 8'h58, 32'h00000026, 1'b1);
    cpu(7'h02, 8'h58, 32'h0000002C, 1'b1);
    cpu(7'h04, 8'h58, 32'h0000002C, 1'b1);
    cpu(7'h08, 8'h58, 32'h0000001A, 1'b1);
    cpu(7'h10, 8'h58, 32'h0000000E, 1'b1);
    cpu(7'h20, 8'h58, 32'h00000000, 1'b0);
    cpu(7'h20, 8'h48, 32'h00000008, 1'b1);
    cpu(7'h20, 8'h50, 32'h00000008, 1'b1);
    cpu(7'h20, 8'hDC, 32'h00000008, 1'b1);
    cpu(7'h20, 8'h39, 32'h00000014, 1'b1);
    cpu(7'h20, 8'h3A, 32'h00000000, 1'b0);
    cpu(7'h20, 8'h5A, 32'h00000014, 1'b1);
    cpu(7'h20, 8'h5B, 32'h00000014, 1'b1);
    apb(1'b1, 12'h010, 32'h00000100);
    cpu(7'h40, 8'h58, 32'h00000000, 1'b0);
    apb(1'b1, 12'h00C, 32'h00000001);
    cpu(7'h40, 8'h58, 32'h0000003E, 1'b1);
    apb(1'b1, 12'h000, 32'h0000020E);
    apb(1'b1, 12'h004, 32'h00F05050);
    apb(1'b1, 12'h008, 32'h00000090);
    irq_set(16'h0024);
    step(2);
    chkb("level zero or masked", 1'b0, ext_irq);
    irq_set(16'h002E);
    chkb("ext irq", 1'b1, ext_irq);
    step(2);
    chk("taken", 32'h00000001, {24'h000000, n_irq});
    apb(1'b0, 12'h014, 32'h00000000);
    chk("status", 32'h00000115, q);
    chkb("same level", 1'b0, ext_irq);
    irq_set(16'h022E);
    chkb("higher level", 1'b1, ext_irq);
    step(2);
    apb(1'b0, 12'h014, 32'h00000000);
    chk("status", 32'h00000199, q);
    irq_set(16'h002C);
    apb(1'b1, 12'h00C, 32'h00000004);
    step(2);
    chk("taken", 32'h00000002, {24'h000000, n_irq});
    apb(1'b1, 12'h00C, 32'h00000004);
    step(3);
    chk("taken", 32'h00000003, {24'h000000, n_irq});
    @(posedge pclk);
    sleep <= 1'b1;
    irq <= 16'h022C;
    step(2);
    chkb("sleep irq", 1'b0, ext_irq);
    chkb("wake", 1'b1, wake_req);
    apb(1'b0, 12'h01C, 32'h00000000);
    chkb("unmapped", 1'b1, err);
    chk("unmapped data", 32'h00000000, q);
    final_report;
  end
endmodule
